/* pkg/atg_pkg.sv */
package atg_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
    // one counted cycle: first value of an interval and the step
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    // present guard time, default 40 ms (plain default)
    localparam int unsigned PRESENT_GUARD_US = 40_000;
    localparam logic [CNT_W-1:0] PRESENT_GUARD_CYC =
        CNT_W'((PRESENT_GUARD_US * (CLK_HZ / 1_000_000)));
    // absent guard time, default 0 (released at once)
    localparam int unsigned ABSENT_GUARD_US = 0;
    localparam logic [CNT_W-1:0] ABSENT_GUARD_CYC =
        CNT_W'((ABSENT_GUARD_US * (CLK_HZ / 1_000_000)));
    localparam logic DETECTED_N_RESET = 1'b1;
    typedef enum logic [1:0] {ATG_IDLE, ATG_QUAL, ATG_ALERT, ATG_HOLD}
        atg_state_t;
endpackage

/* core/atg_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module atg_sync
    import atg_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

/* core/atg_guard_timer.sv */
// Contract
// - input high only while both tones present
// - assert after present guard time uninterrupted
// - release after absent guard time of low
// - early drop restarts full present interval
// - early return keeps output, restarts absent interval
// - absent guard may be zero, immediate release
// - onset latency is front delay plus present
// - release latency is front delay plus absent
// - shared pin carries alert only in alert mode
`timescale 1ns/1ns
`default_nettype none
module atg_guard_timer
    import atg_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_tone_pair_present,
    input wire logic i_alert_mode_sel,
    input wire logic i_fsk_ready_n,
    input wire logic [CNT_W-1:0] i_present_guard_cyc,
    input wire logic [CNT_W-1:0] i_absent_guard_cyc,
    output logic o_alert_detected_n,
    output logic o_shared_ready_or_alert_pin,
    output logic [CNT_W-1:0] o_guard_timing_node
);
    logic tone_s;
    atg_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic det_n_q;
    logic present_instant;
    logic absent_instant;
    logic present_done;
    logic absent_done;

    // tone indication arrives from another block's timing: synchronise
    atg_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_tone_pair_present),
        .o_sync(tone_s)
    );

    // terminal of zero or one: first qualifying cycle ends the interval
    function automatic logic guard_instant(input logic [CNT_W-1:0] term);
        return term <= CNT_ONE;
    endfunction

    // count includes this cycle, hence terminal minus one
    function automatic logic guard_expired(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] term
    );
        return (cnt + CNT_ONE) >= term;
    endfunction

    assign present_instant = guard_instant(i_present_guard_cyc);
    assign absent_instant = guard_instant(i_absent_guard_cyc);
    assign present_done = guard_expired(cnt_q, i_present_guard_cyc);
    assign absent_done = guard_expired(cnt_q, i_absent_guard_cyc);

    // guard state: moves only on the synchronised tone indication
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= ATG_IDLE;
        end
        else
        begin
            unique case (state_q)
                ATG_IDLE:
                begin
                    if (tone_s)
                    begin
                        if (present_instant)
                        begin
                            state_q <= ATG_ALERT;
                        end
                        else
                        begin
                            state_q <= ATG_QUAL;
                        end
                    end
                end
                ATG_QUAL:
                begin
                    if (!tone_s)
                    begin
                        state_q <= ATG_IDLE;
                    end
                    else if (present_done)
                    begin
                        state_q <= ATG_ALERT;
                    end
                end
                ATG_ALERT:
                begin
                    if (!tone_s)
                    begin
                        if (absent_instant)
                        begin
                            state_q <= ATG_IDLE;
                        end
                        else
                        begin
                            state_q <= ATG_HOLD;
                        end
                    end
                end
                ATG_HOLD:
                begin
                    if (tone_s)
                    begin
                        state_q <= ATG_ALERT;
                    end
                    else if (absent_done)
                    begin
                        state_q <= ATG_IDLE;
                    end
                end
            endcase
        end
    end

    // one counter serves both intervals, as they never overlap
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= CNT_RESET;
        end
        else
        begin
            unique case (state_q)
                ATG_IDLE:
                begin
                    if (tone_s && !present_instant)
                    begin
                        cnt_q <= CNT_ONE;
                    end
                    else
                    begin
                        cnt_q <= CNT_RESET;
                    end
                end
                ATG_QUAL:
                begin
                    // a dropout throws the elapsed time away
                    if (!tone_s || present_done)
                    begin
                        cnt_q <= CNT_RESET;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + CNT_ONE;
                    end
                end
                ATG_ALERT:
                begin
                    if (!tone_s && !absent_instant)
                    begin
                        cnt_q <= CNT_ONE;
                    end
                    else
                    begin
                        cnt_q <= CNT_RESET;
                    end
                end
                ATG_HOLD:
                begin
                    if (tone_s || absent_done)
                    begin
                        cnt_q <= CNT_RESET;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + CNT_ONE;
                    end
                end
            endcase
        end
    end

    // detected output changes only where the state enters ALERT from IDLE/QUAL or IDLE from ALERT/HOLD
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            det_n_q <= DETECTED_N_RESET;
        end
        else
        begin
            unique case (state_q)
                ATG_IDLE:
                begin
                    if (tone_s && present_instant)
                    begin
                        det_n_q <= 1'b0;
                    end
                end
                ATG_QUAL:
                begin
                    if (tone_s && present_done)
                    begin
                        det_n_q <= 1'b0;
                    end
                end
                ATG_ALERT:
                begin
                    if (!tone_s && absent_instant)
                    begin
                        det_n_q <= 1'b1;
                    end
                end
                ATG_HOLD:
                begin
                    if (!tone_s && absent_done)
                    begin
                        det_n_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign o_alert_detected_n = det_n_q;
    assign o_guard_timing_node = cnt_q;
    // hold-off after detection is left to the host software
    assign o_shared_ready_or_alert_pin =
        i_alert_mode_sel ? det_n_q : i_fsk_ready_n;
endmodule
`default_nettype wire

/* tb/atg_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module atg_checker
    import atg_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_tone_pair_present,
    input wire logic i_alert_mode_sel,
    input wire logic i_fsk_ready_n,
    input wire logic [CNT_W-1:0] i_present_guard_cyc,
    input wire logic [CNT_W-1:0] i_absent_guard_cyc,
    input wire logic o_alert_detected_n,
    input wire logic o_shared_ready_or_alert_pin,
    input wire logic [CNT_W-1:0] o_guard_timing_node
);
    wire logic d = o_alert_detected_n;
    wire logic r = i_tone_pair_present;
    wire logic [CNT_W-1:0] n = o_guard_timing_node;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    AST_MUX: assert property (o_shared_ready_or_alert_pin ===
        (i_alert_mode_sel ? d : i_fsk_ready_n)) else $error("pin mux");
    AST_ON: assert property ($fell(d) |-> $past(r, 3)
        && $past(n) == i_present_guard_cyc - 1) else $error("onset");
    AST_OFF: assert property ($rose(d) |-> !$past(r, 3))
        else $error("release");
    AST_OFFCNT: assert property ($rose(d) && i_absent_guard_cyc > 1
        |-> $past(n) == i_absent_guard_cyc - 1) else $error("absent");
    AST_DROP: assert property (d && !$past(r, 3) |-> n == 0)
        else $error("restart");
    AST_BACK: assert property (!d && $past(r, 3) |-> n == 0)
        else $error("hold");
    AST_BOUND: assert property (d |-> n < i_present_guard_cyc)
        else $error("count");
    AST_CLR: assert property ($changed(d) |-> n == 0)
        else $error("clear");
    cover property ($fell(d));
    cover property ($rose(d));
    cover property (!d && r ##1 !r);
endmodule
bind atg_guard_timer atg_checker chk_u (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_tone_pair_present(i_tone_pair_present),
    .i_alert_mode_sel(i_alert_mode_sel),
    .i_fsk_ready_n(i_fsk_ready_n),
    .i_present_guard_cyc(i_present_guard_cyc),
    .i_absent_guard_cyc(i_absent_guard_cyc),
    .o_alert_detected_n(o_alert_detected_n),
    .o_shared_ready_or_alert_pin(o_shared_ready_or_alert_pin),
    .o_guard_timing_node(o_guard_timing_node)
);
`default_nettype wire

/* tb/atg_tone_src.sv */
`timescale 1ns/1ns
`default_nettype none
module atg_tone_src
#(
    // host hold-off, two seconds of clock cycles by default
    parameter int HOLDOFF_CYC = 40_000_000
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_tone_lo,
    input wire logic i_tone_hi,
    input wire logic i_alert_detected_n,
    output logic o_tone_pair_present,
    output logic [15:0] o_accept_cnt
);
    int hold_q;
    logic det_prev_q;

    // one cycle onset and loss delay
    always_ff @(posedge i_core_clk)
    begin
        o_tone_pair_present <= i_tone_lo & i_tone_hi;
    end

    // host: detections inside the hold-off are taken as speech
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            det_prev_q <= 1'b1;
            hold_q <= 0;
            o_accept_cnt <= 16'h0000;
        end
        else
        begin
            det_prev_q <= i_alert_detected_n;
            if (det_prev_q && !i_alert_detected_n && hold_q == 0)
            begin
                hold_q <= HOLDOFF_CYC;
                o_accept_cnt <= o_accept_cnt + 16'h0001;
            end
            else if (hold_q != 0)
            begin
                hold_q <= hold_q - 1;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import atg_pkg::*;
    logic clk = 0, rst = 1, ta = 0, tb_h = 0, sel = 0, fsk = 1, s;
    // hold-off scaled down so that a short pass exercises it
    localparam int HOLD_CYC = 40;
    logic [CNT_W-1:0] ag = 0, pg = 0;
    logic [1:0] h = 0;
    logic [7:0] r = 8'h0b;
    wire logic raw, det, pin;
    wire logic [CNT_W-1:0] node;
    wire logic [15:0] acc_seen;
    int error_cnt = 0, cmp_count = 0, al = 0, c = 0;
    int pa = 0, hd = 0, acc = 0;
    int av[3] = '{0, 1, 3};
    int pv[3] = '{5, 1, 4};
    always #25 clk = ~clk;
    atg_tone_src #(.HOLDOFF_CYC(HOLD_CYC)) src_u (.i_core_clk(clk),
        .i_rst(rst), .i_tone_lo(ta), .i_tone_hi(tb_h),
        .i_alert_detected_n(det), .o_tone_pair_present(raw),
        .o_accept_cnt(acc_seen));
    atg_guard_timer dut_u (.i_core_clk(clk), .i_rst(rst),
        .i_tone_pair_present(raw), .i_alert_mode_sel(sel),
        .i_fsk_ready_n(fsk), .i_present_guard_cyc(pg),
        .i_absent_guard_cyc(ag), .o_alert_detected_n(det),
        .o_shared_ready_or_alert_pin(pin), .o_guard_timing_node(node));
    function automatic logic [7:0] lf(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic [CNT_W-1:0] g, e);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("cmp %0d err %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // mirror: two-edge sync, then present/absent counts
    always @(posedge clk or posedge rst)
    begin
        s = h[1];
        h = {h[0], raw};
        // host sees the output one edge late, then holds off
        if (al == 1 && pa == 0 && hd == 0)
        begin
            acc++;
            hd = HOLD_CYC;
        end
        else if (hd > 0)
            hd--;
        pa = al;
        if (rst)
        begin
            al = 0;
            c = 0;
            h = 0;
            pa = 0;
            hd = 0;
            acc = 0;
        end
        else if (al == 0)
        begin
            c = s ? c + 1 : 0;
            if (s && c >= pg)
            begin
                al = 1;
                c = 0;
            end
        end
        else if (s)
            c = 0;
        else if (++c >= ag)
        begin
            al = 0;
            c = 0;
        end
    end
    always @(negedge clk)
    begin
        chk(CNT_W'(det), CNT_W'(al == 0));
        chk(node, CNT_W'(c));
        chk(CNT_W'(pin), CNT_W'(sel ? al == 0 : fsk));
    end
    initial
    begin
        for (int i = 0; i < 3; i++)
        begin
            rst <= 1;
            ag <= CNT_W'(av[i]);
            pg <= CNT_W'(pv[i]);
            repeat (8) @(posedge clk);
            rst <= 0;
            repeat (60)
            begin
                r = lf(r);
                ta <= r[7] | r[6];
                tb_h <= r[7] | r[5];
                sel <= r[4] | r[3];
                fsk <= r[0];
                repeat (r[2:0] + 1) @(posedge clk);
            end
            @(negedge clk);
            chk(CNT_W'(acc_seen), CNT_W'(acc));
            $display("absent guard %0d done", av[i]);
            @(posedge clk);
        end
        conclude();
    end
endmodule
`default_nettype wire
